// >>> bench/pcsc_axil_master.sv
// axi4-lite master standing in for the configuring software
// assumes: bench pulses req for one cycle while idle, holds payload until done
`timescale 1ns/1ps
module pcsc_axil_master (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic req_we,
  input wire logic [3:0] req_addr,
  input wire logic [31:0] req_data,
  input wire logic [3:0] req_strb,
  output logic done,
  output logic [31:0] rsp_data,
  output logic [1:0] rsp_resp,
  output logic [3:0] s_axil_awaddr,
  output logic s_axil_awvalid,
  input wire logic s_axil_awready,
  output logic [31:0] s_axil_wdata,
  output logic [3:0] s_axil_wstrb,
  output logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  output logic s_axil_bready,
  output logic [3:0] s_axil_araddr,
  output logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  output logic s_axil_rready
);
  logic busy_ff;  // one transfer at a time
  // payload follows request lines, held by the bench until done
  assign s_axil_awaddr = req_addr;
  assign s_axil_araddr = req_addr;
  assign s_axil_wdata = req_data;
  assign s_axil_wstrb = req_strb;
  // launch, release each channel at its own handshake, take the answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= 1'b0;
      done <= 1'b0;
      s_axil_awvalid <= 1'b0;
      s_axil_wvalid <= 1'b0;
      s_axil_bready <= 1'b0;
      s_axil_arvalid <= 1'b0;
      s_axil_rready <= 1'b0;
      rsp_data <= 32'h0;
      rsp_resp <= 2'h0;
    end else begin
      done <= 1'b0;
      if (req && !busy_ff) begin
        busy_ff <= 1'b1;
        s_axil_awvalid <= req_we;
        s_axil_wvalid <= req_we;
        s_axil_bready <= req_we;
        s_axil_arvalid <= !req_we;
        s_axil_rready <= !req_we;
      end
      if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'b0;
      if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'b0;
      // ready held until the answer is seen
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bready <= 1'b0;
        busy_ff <= 1'b0;
        done <= 1'b1;
        rsp_resp <= s_axil_bresp;
      end
      if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rready <= 1'b0;
        busy_ff <= 1'b0;
        done <= 1'b1;
        rsp_data <= s_axil_rdata;
        rsp_resp <= s_axil_rresp;
      end
    end
  end
endmodule

// >>> bench/pll_clock_synthesis_control_bench.sv
// bench for the loop clock control: bus scenarios, verdict at the end
// assumes: partner master in pcsc_axil_master.sv, one 200 MHz clock
`timescale 1ns/1ps
module pll_clock_synthesis_control_bench import pcsc_pkg::*;;
  localparam int LOCK = 20;  // shortened lock-in interval
  logic aclk, aresetn, clk_en, req, req_we, done, irq, lock_flag;
  logic [3:0] req_addr, req_strb, s_axil_awaddr, s_axil_wstrb, s_axil_araddr;
  logic [31:0] req_data, rsp_data, s_axil_wdata, s_axil_rdata;
  logic [1:0] rsp_resp, s_axil_bresp, s_axil_rresp;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid, s_axil_bready;
  logic s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  logic [15:0] periph_off;
  pcsc_settings_type loop_settings;
  int error_cnt, num_checks;
  pcsc_ctrl #(.LOCK_CYCLES(LOCK)) u_dut (.*);
  pcsc_axil_master u_sw (.*);
  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one transfer through the partner, entered right after an edge
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    req <= 1'b1;
    req_we <= we;
    req_addr <= a;
    req_data <= d;
    req_strb <= s;
    @(posedge aclk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (done !== 1'b1 && n < 300);
    chk(32'(n < 300), 32'h1);
    chk(rsp_resp, 32'h0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(rsp_data, exp);
  endtask
  // bounded wait for the lock flag, returns cycles spent
  task automatic wait_lock(output int n);
    n = 0;
    while (lock_flag !== 1'b1 && n < 1000) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic t_reset;
    chk(32'(loop_settings), 32'h0);
    chk(lock_flag, 32'h0);
    rdc(4'h0, 32'h0);
    rdc(4'h4, 32'h0);
  endtask
  task automatic t_gating;
    wr(4'h4, 32'hffff181f);
    chk(periph_off, 32'h181f);
    rdc(4'h4, 32'h181f);
    bus(1'b1, 4'h4, 32'hff, 4'h1);
    rdc(4'h4, 32'h18ff);
    wr(4'h4, 32'h0);
    chk(periph_off, 32'h0);
  endtask
  task automatic t_lock;
    int n;
    wr(4'hc, 32'h7);
    // filter 0111 suits M 12, N 1 keeps the loop in its band
    wr(4'h0, 32'h872c);
    chk(lock_flag, 32'h0);
    wait_lock(n);
    chk(32'(n >= LOCK - 4 && n <= LOCK + 1), 32'h1);
    chk(irq, 32'h1);
    rdc(4'h8, 32'h101);
    // loop selected only once locked
    wr(4'h0, 32'hc72c);
    chk(32'(loop_settings), 32'hc72c);
    wr(4'h8, 32'h7);
    rdc(4'h8, 32'h100);
    chk(irq, 32'h0);
  endtask
  task automatic t_down;
    int n;
    wr(4'h0, 32'h072c);
    chk(lock_flag, 32'h0);
    rdc(4'h8, 32'h2);
    wr(4'h8, 32'h7);
    wr(4'h0, 32'h872c);
    // frozen clock enable must stall the fresh lock-in count
    clk_en <= 1'b0;
    repeat (LOCK + 10) @(posedge aclk);
    chk(lock_flag, 32'h0);
    clk_en <= 1'b1;
    wait_lock(n);
    chk(32'(n >= LOCK - 5 && n <= LOCK), 32'h1);
    wr(4'h0, 32'h0);
  endtask
  task automatic t_filter;
    logic [4:0] m_tab [7] = '{5'h18, 5'h15, 5'h14, 5'h10, 5'h0f, 5'h08, 5'h02};
    logic [3:0] c_tab [7] = '{4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6, 4'h4};
    wr(4'h8, 32'h7);
    for (int i = 0; i < 7; i++) begin
      wr(4'h0, {20'h0, c_tab[i], 3'h1, m_tab[i]});
      rdc(4'h8, 32'h0);
    end
    wr(4'h0, 32'h042c);
    rdc(4'h8, 32'h4);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog well past the expected run length
  initial begin
    #25000;
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    req = 1'b0;
    req_we = 1'b0;
    req_addr = 4'h0;
    req_data = 32'h0;
    req_strb = 4'h0;
    // clock runs through a 16 cycle reset
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_gating();
    t_lock();
    t_down();
    t_filter();
    final_report();
  end
endmodule

// >>> core/pcsc_ctrl.sv
// loop clock synthesis control: settings, lock timing, peripheral gating, axi4-lite slave
// assumes: one clock aclk at 200 MHz, synchronous active-low aresetn, clk_en freezes all state
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pcsc_map.svh"

// Function
// R1: loop powered only while power bit set
// R2: core clock from pin unless select set
// R3: core clock is input times M over 2N
// R4: software keeps loop output 50 to 120 MHz
// R5: filter code must match M per table
// R6: lock flag set after 30 us lock-in
// R7: software selects loop only after lock
// R8: input clock runs six cycles during reset
// R9: gating word 0x0000 runs, 0x181f stops peripherals
// R10: power-down clears lock flag immediately
module pcsc_ctrl import pcsc_pkg::*; #(
  parameter int LOCK_CYCLES = `PCSC_LOCK_CYCLES  // lock-in interval in aclk cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [3:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [3:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output pcsc_settings_type loop_settings,
  output logic lock_flag,
  output logic [15:0] periph_off,
  output logic irq
);

  // lock counter must hold the interval and count at least one cycle
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_bad_lock
    $error("pcsc_ctrl: LOCK_CYCLES out of range");
  end

  // filter code that suits a multiplier, zero where M is not usable
  function automatic logic [3:0] filter_for_m(input logic [4:0] m);
    logic [3:0] code;
    code = 4'h0;
    if (m >= 5'h17 && m <= 5'h18) begin
      code = 4'hb;
    end else if (m >= 5'h15) begin
      code = (m <= 5'h16) ? 4'ha : 4'h0;
    end else if (m >= 5'h13) begin
      code = 4'h9;
    end else if (m >= 5'h10) begin
      code = 4'h8;
    end else if (m >= 5'h0c) begin
      code = 4'h7;
    end else if (m >= 5'h08) begin
      code = 4'h6;
    end else if (m >= 5'h02) begin
      code = 4'h4;
    end
    return code;
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  pcsc_settings_type settings_ff;  // loop settings word
  logic [15:0] gating_ff;           // peripheral power gating word
  pcsc_events_type status_ff;       // sticky events
  pcsc_events_type mask_ff;         // interrupt enables
  logic lock_ff;                    // lock flag
  logic [15:0] lock_cnt_ff;         // cycles since power-up, held once locked
  logic irq_ff;                     // interrupt line
  pcsc_wr_state_type wr_state_ff;   // write channel state
  logic aw_held_ff;                 // write address taken
  logic w_held_ff;                  // write data taken
  logic [3:0] awaddr_ff;            // held write address
  logic [31:0] wdata_ff;            // held write data
  logic [3:0] wstrb_ff;             // held strobes
  logic awready_ff;                 // address ready
  logic wready_ff;                  // data ready
  logic bvalid_ff;                  // write response valid
  logic [1:0] bresp_ff;             // write response code
  logic arready_ff;                 // read address ready
  logic rvalid_ff;                  // read data valid
  logic [31:0] rdata_ff;            // read data
  logic [1:0] rresp_ff;             // read response code

  logic do_write;         // both halves present, perform write this cycle
  logic wr_settings;      // write hits the settings word
  logic wr_gating;        // write hits the gating word
  logic wr_status;        // write hits status (one clears)
  logic wr_mask;          // write hits the mask
  logic lock_done;        // lock-in interval ends this cycle
  logic lock_drop;        // locked loop is powered down
  pcsc_events_type evt;   // events raised this cycle
  pcsc_events_type w1c;   // bits software clears this cycle
  pcsc_events_type nxt_status;
  logic [15:0] nxt_settings;

  assign do_write = aw_held_ff && w_held_ff && (wr_state_ff == PCSC_WR_IDLE);
  assign wr_settings = do_write && (awaddr_ff == `PCSC_OFS_SETTINGS);
  assign wr_gating = do_write && (awaddr_ff == `PCSC_OFS_GATING);
  assign wr_status = do_write && (awaddr_ff == `PCSC_OFS_STATUS);
  assign wr_mask = do_write && (awaddr_ff == `PCSC_OFS_MASK);
  assign nxt_settings = merge16(settings_ff, wdata_ff, wstrb_ff);

  // register outputs straight from flops
  assign loop_settings = settings_ff;
  assign lock_flag = lock_ff;
  assign periph_off = gating_ff;
  assign irq = irq_ff;
  assign s_axil_awready = awready_ff;
  assign s_axil_wready = wready_ff;
  assign s_axil_bvalid = bvalid_ff;
  assign s_axil_bresp = bresp_ff;
  assign s_axil_arready = arready_ff;
  assign s_axil_rvalid = rvalid_ff;
  assign s_axil_rdata = rdata_ff;
  assign s_axil_rresp = rresp_ff;

  // write address and data are taken independently, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `PCSC_RESP_OKAY;
      wr_state_ff <= PCSC_WR_IDLE;
    end else if (clk_en) begin
      // readies rise one cycle after reset, drop on the taking edge
      awready_ff <= !aw_held_ff && !(awready_ff && s_axil_awvalid) && (wr_state_ff == PCSC_WR_IDLE);
      wready_ff <= !w_held_ff && !(wready_ff && s_axil_wvalid) && (wr_state_ff == PCSC_WR_IDLE);
      if (awready_ff && s_axil_awvalid) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= {s_axil_awaddr[3:2], 2'b00};
      end
      if (wready_ff && s_axil_wvalid) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axil_wdata;
        wstrb_ff <= s_axil_wstrb;
      end
      unique case (wr_state_ff)
        PCSC_WR_IDLE: begin
          if (do_write) begin
            bvalid_ff <= 1'b1;
            // unmapped words answer slverr and change nothing
            bresp_ff <= (awaddr_ff == `PCSC_OFS_SETTINGS || awaddr_ff == `PCSC_OFS_GATING ||
                         awaddr_ff == `PCSC_OFS_STATUS || awaddr_ff == `PCSC_OFS_MASK) ?
                        `PCSC_RESP_OKAY : `PCSC_RESP_SLVERR;
            wr_state_ff <= PCSC_WR_RESP;
          end
        end
        PCSC_WR_RESP: begin
          if (s_axil_bready) begin
            bvalid_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            wr_state_ff <= PCSC_WR_IDLE;
          end
        end
      endcase
    end
  end

  // read channel, data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `PCSC_RESP_OKAY;
    end else if (clk_en) begin
      if (rvalid_ff) begin
        if (s_axil_rready) begin
          rvalid_ff <= 1'b0;
          arready_ff <= 1'b1;
        end
      end else if (arready_ff && s_axil_arvalid) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= `PCSC_RESP_OKAY;
        unique case ({s_axil_araddr[3:2], 2'b00})
          `PCSC_OFS_SETTINGS: rdata_ff <= {16'h0, settings_ff};
          `PCSC_OFS_GATING: rdata_ff <= {16'h0, gating_ff};
          `PCSC_OFS_STATUS: rdata_ff <= {23'h0, lock_ff, 5'h0, status_ff};
          `PCSC_OFS_MASK: rdata_ff <= {29'h0, mask_ff};
          default: begin
            rdata_ff <= 32'h0;
            rresp_ff <= `PCSC_RESP_SLVERR;
          end
        endcase
      end else begin
        arready_ff <= 1'b1;
      end
    end
  end

  // settings word; power and select bits reset to zero, pin clock, loop off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settings_ff <= `PCSC_RST_SETTINGS;
    end else if (clk_en && wr_settings) begin
      // R1 power bit steers loop
      // R2 select bit picks clock
      // R3 m and n reach the synthesiser
      settings_ff <= nxt_settings;
    end
  end

  // gating word drives the peripheral power switches bit for bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gating_ff <= `PCSC_RST_GATING;
    end else if (clk_en && wr_gating) begin
      // R9 gating word to switches
      gating_ff <= merge16(gating_ff, wdata_ff, wstrb_ff);
    end
  end

  // lock-in timer; the loop output is untrusted until it expires
  assign lock_done = settings_ff.power_on && !lock_ff && (lock_cnt_ff == 16'(LOCK_CYCLES - 1));
  assign lock_drop = !settings_ff.power_on && lock_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_cnt_ff <= 16'h0;
      lock_ff <= 1'b0;
    end else if (clk_en) begin
      if (!settings_ff.power_on) begin
        // R10 power-down restarts lock-in
        lock_cnt_ff <= 16'h0;
        lock_ff <= 1'b0;
      end else if (lock_done) begin
        // R6 lock flag after interval
        lock_ff <= 1'b1;
      end else if (!lock_ff) begin
        lock_cnt_ff <= lock_cnt_ff + 16'h1;
      end
    end
  end

  // events; a filter code that does not suit M is flagged, not corrected
  always_comb begin
    evt = '0;
    evt.locked = lock_done;
    evt.lock_lost = lock_drop;
    // R5 filter code against m
    evt.filter_bad = wr_settings && (nxt_settings[`PCSC_FILT_HI:`PCSC_FILT_LO] != filter_for_m(nxt_settings[4:0]));
    w1c = wr_status && wstrb_ff[0] ? pcsc_events_type'(wdata_ff[2:0]) : '0;
    // a new event wins over a clear in the same cycle
    nxt_status = (status_ff & ~w1c) | evt;
  end

  // sticky status, mask and interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      status_ff <= nxt_status;
      if (wr_mask && wstrb_ff[0]) begin
        mask_ff <= pcsc_events_type'(wdata_ff[2:0]);
      end
      irq_ff <= |(nxt_status & (wr_mask && wstrb_ff[0] ? pcsc_events_type'(wdata_ff[2:0]) : mask_ff));
    end
  end

  // assertions
  sequence s_power_up;
    settings_ff.power_on && !$past(settings_ff.power_on);
  endsequence
  sequence s_settings_write;
    wr_settings && clk_en;
  endsequence

  lock_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    !settings_ff.power_on && clk_en |=> !lock_ff)
    else $error("lock flag held while loop powered down");
  lock_early_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    lock_ff |-> lock_cnt_ff == 16'(LOCK_CYCLES - 1))
    else $error("lock flag set before interval elapsed");
  lock_rise_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    $rose(lock_ff) |-> $past(settings_ff.power_on) && $past(clk_en))
    else $error("lock flag rose without power");
  power_up_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    s_power_up |-> !lock_ff && lock_cnt_ff <= 16'h1)
    else $error("power-up did not start a fresh lock-in");
  power_bit_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    s_settings_write |=> loop_settings.power_on == $past(nxt_settings[`PCSC_BIT_POWER]))
    else $error("power bit not taken from write");
  select_bit_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    s_settings_write |=> loop_settings.clock_select == $past(nxt_settings[`PCSC_BIT_SELECT]))
    else $error("select bit not taken from write");
  ratio_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    s_settings_write |=> {loop_settings.mult_m, loop_settings.div_n} == $past({nxt_settings[4:0], nxt_settings[7:5]}))
    else $error("m or n not taken from write");
  filter_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    s_settings_write and (nxt_settings[11:8] != filter_for_m(nxt_settings[4:0])) |=> status_ff.filter_bad)
    else $error("unsuited filter code not flagged");
  gating_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    wr_gating && clk_en && wstrb_ff[1:0] == 2'b11 |=> periph_off == $past(wdata_ff[15:0]))
    else $error("gating word not applied");
  irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> irq == |($past(nxt_status) & mask_ff))
    else $error("interrupt line does not follow status and mask");
  bresp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && clk_en |=> s_axil_bvalid)
    else $error("no write response after write");

endmodule

// >>> core/pcsc_map.svh
// register offsets, field positions, reset values and timing for the loop clock control
// assumes: included by bare name from core files only
`ifndef PCSC_MAP_SVH
`define PCSC_MAP_SVH
`define PCSC_OFS_SETTINGS 4'h0
`define PCSC_OFS_GATING 4'h4
`define PCSC_OFS_STATUS 4'h8
`define PCSC_OFS_MASK 4'hc
`define PCSC_BIT_POWER 15
`define PCSC_BIT_SELECT 14
`define PCSC_FILT_HI 11
`define PCSC_FILT_LO 8
`define PCSC_BIT_LOCK 8
`define PCSC_RST_SETTINGS 16'h0000
`define PCSC_RST_GATING 16'h0000
`define PCSC_GATING_ALL_OFF 16'h181f
`define PCSC_EVT_LOCKED 0
`define PCSC_EVT_LOST 1
`define PCSC_EVT_FILTER 2
`define PCSC_LOCK_TIME_US 30
`define PCSC_CLK_MHZ 200
`define PCSC_LOCK_CYCLES (`PCSC_LOCK_TIME_US * `PCSC_CLK_MHZ)
`define PCSC_RESP_OKAY 2'h0
`define PCSC_RESP_SLVERR 2'h2
`endif

// >>> core/pcsc_pkg.sv
// types of the loop clock control block
// assumes: offsets and counts come from pcsc_map.svh
package pcsc_pkg;
  // loop settings word, layout as software sees it
  typedef struct packed {
    logic power_on;      // loop powered when set
    logic clock_select;  // core clock from loop when set
    logic [1:0] spare;   // reads back as written
    logic [3:0] filter;  // loop filter code
    logic [2:0] div_n;   // divider N
    logic [4:0] mult_m;  // multiplier M
  } pcsc_settings_type;
  // sticky event bits, same layout for status and mask
  typedef struct packed {
    logic filter_bad;  // filter code does not suit M
    logic lock_lost;   // loop powered down while locked
    logic locked;      // lock-in interval finished
  } pcsc_events_type;
  // write channel progress
  typedef enum logic [1:0] {
    PCSC_WR_IDLE = 2'b00,
    PCSC_WR_RESP = 2'b01
  } pcsc_wr_state_type;
endpackage
